// >>> verilog/sct_start_trigger.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module sct_start_trigger #(
    parameter int unsigned HOLD_W = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus state from the rest of the controller.
    input wire logic bus_busy,
    input wire logic master_wait,
    input wire logic arb_lost,
    input wire logic stop_detected,
    input wire logic engine_ack,
    // Open-drain data line.
    input wire logic bus_data_line_in,
    output logic bus_data_line_out,
    output logic bus_data_line_oe,
    // Open-drain clock line.
    input wire logic bus_clock_line_in,
    output logic bus_clock_line_out,
    output logic bus_clock_line_oe,
    // Status toward the rest of the controller.
    output logic start_done,
    output logic master_state_flag
);

    // The hold counter must at least cover the reset interval.
    if (HOLD_W < 8 || HOLD_W > 32) begin : g_bad_width
        $error("HOLD_W must lie between 8 and 32");
    end

    typedef struct packed {
        sct_pkg::sct_fsm_t fsm;
        logic enable;
        logic trig;
        logic msts;
        logic [HOLD_W-1:0] rate;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic sda_oe;
        logic scl_oe;
        logic start_done;
    } sct_state_t;

    sct_state_t state_reg;
    sct_state_t state_next;
    logic tmr_load;
    logic tmr_expired;
    logic [HOLD_W-1:0] tmr_val;
    logic access;
    logic wr_ctrl;
    logic wr_set;
    logic wr_clr;
    logic en_now;
    logic abort;

    // Tells whether an address hits one of the three registers.
    function automatic logic reg_mapped(input logic [11:0] addr);
        return addr == sct_pkg::OFS_CTRL || addr == sct_pkg::OFS_STATUS
            || addr == sct_pkg::OFS_HOLD;
    endfunction : reg_mapped

    // A rate of zero would stall the sequencer, so it counts as one cycle.
    function automatic logic [HOLD_W-1:0] hold_len(input logic [HOLD_W-1:0] r);
        return (r == '0) ? HOLD_W'(1) : r;
    endfunction : hold_len

    sct_hold_timer #(
        .CNT_W(HOLD_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_expired)
    );

    // Write decode: a write takes effect at the edge where pready is high.
    assign access = psel && penable && state_reg.pready;
    assign wr_ctrl = access && pwrite && paddr == sct_pkg::OFS_CTRL;
    assign wr_set = wr_ctrl && pwdata[sct_pkg::CTRL_START_BIT];
    assign wr_clr = wr_ctrl && !pwdata[sct_pkg::CTRL_START_BIT];
    assign en_now = wr_ctrl ? pwdata[sct_pkg::CTRL_EN_BIT] : state_reg.enable;
    assign abort = !en_now || arb_lost
        || (wr_ctrl && pwdata[sct_pkg::CTRL_EXIT_BIT]);
    assign tmr_val = hold_len(state_reg.rate);

    // Next state: bus slave, start sequencer, trigger and master flag.
    always_comb begin
        state_next = state_reg;
        tmr_load = 1'b0;
        state_next.start_done = 1'b0;
        // APB answer one cycle into the access phase.
        state_next.pready = psel && penable && !state_reg.pready;
        state_next.pslverr = psel && penable && !state_reg.pready
            && !reg_mapped(paddr);
        if (psel && penable && !state_reg.pready) begin
            state_next.prdata = 32'h0000_0000;
            if (!pwrite && paddr == sct_pkg::OFS_CTRL) begin
                // Start, stop and exit bits read as zero.
                state_next.prdata[sct_pkg::CTRL_EN_BIT] = state_reg.enable;
            end else if (!pwrite && paddr == sct_pkg::OFS_STATUS) begin
                state_next.prdata[sct_pkg::STAT_MSTS_BIT] = state_reg.msts;
                state_next.prdata[sct_pkg::STAT_PEND_BIT] = state_reg.trig;
                state_next.prdata[sct_pkg::STAT_BUSY_BIT] =
                    state_reg.fsm != sct_pkg::ST_IDLE;
                state_next.prdata[sct_pkg::STAT_SCL_BIT] = bus_clock_line_in;
                state_next.prdata[sct_pkg::STAT_SDA_BIT] = bus_data_line_in;
            end else if (!pwrite && paddr == sct_pkg::OFS_HOLD) begin
                state_next.prdata[HOLD_W-1:0] = state_reg.rate;
            end
        end
        if (wr_ctrl) begin
            state_next.enable = pwdata[sct_pkg::CTRL_EN_BIT];
        end
        if (access && pwrite && paddr == sct_pkg::OFS_HOLD) begin
            state_next.rate = pwdata[HOLD_W-1:0];
        end
        // Start sequencer.
        unique case (state_reg.fsm)
            sct_pkg::ST_IDLE: begin
                state_next.sda_oe = 1'b0;
                state_next.scl_oe = 1'b0;
                if (state_reg.trig && !abort && !wr_clr) begin
                    if (master_wait) begin
                        // Take the clock low ourselves, release data.
                        state_next.fsm = sct_pkg::ST_RS_SDA;
                        state_next.scl_oe = 1'b1;
                        tmr_load = 1'b1;
                    end else if (!bus_busy) begin
                        state_next.fsm = sct_pkg::ST_HOLD;
                        state_next.sda_oe = 1'b1;
                        tmr_load = 1'b1;
                    end
                    // Otherwise the trigger waits as a reserved request.
                end
            end
            sct_pkg::ST_RS_SDA: begin
                if (tmr_expired) begin
                    state_next.fsm = sct_pkg::ST_RS_SCL;
                    state_next.scl_oe = 1'b0;
                    tmr_load = 1'b1;
                end
            end
            sct_pkg::ST_RS_SCL: begin
                // A slave may stretch the clock; time from its release.
                if (!bus_clock_line_in) begin
                    tmr_load = 1'b1;
                end else if (tmr_expired) begin
                    state_next.fsm = sct_pkg::ST_HOLD;
                    state_next.sda_oe = 1'b1;
                    tmr_load = 1'b1;
                end
            end
            sct_pkg::ST_HOLD: begin
                if (tmr_expired) begin
                    state_next.fsm = sct_pkg::ST_DONE;
                    state_next.scl_oe = 1'b1;
                    state_next.start_done = 1'b1;
                end
            end
            sct_pkg::ST_DONE: begin
                // Both lines stay low until the byte engine takes over.
                if (engine_ack) begin
                    state_next.fsm = sct_pkg::ST_IDLE;
                    state_next.sda_oe = 1'b0;
                    state_next.scl_oe = 1'b0;
                end
            end
            default: begin
                state_next.fsm = sct_pkg::ST_IDLE;
                state_next.sda_oe = 1'b0;
                state_next.scl_oe = 1'b0;
            end
        endcase
        if (abort && state_reg.fsm != sct_pkg::ST_IDLE) begin
            state_next.fsm = sct_pkg::ST_IDLE;
            state_next.sda_oe = 1'b0;
            state_next.scl_oe = 1'b0;
            state_next.start_done = 1'b0;
        end
        // Trigger: clears by write, abort or start first, a software set wins over them.
        if (wr_clr || abort || state_next.start_done) begin
            state_next.trig = 1'b0;
        end
        if (wr_set && en_now) begin
            state_next.trig = 1'b1;
        end
        // Master flag: set on a generated start, which wins over clears.
        if (stop_detected || abort) begin
            state_next.msts = 1'b0;
        end
        if (state_next.start_done) begin
            state_next.msts = 1'b1;
        end
    end

    // One register stage for all state.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg.fsm <= sct_pkg::ST_IDLE;
            state_reg.enable <= sct_pkg::RST_ENABLE;
            state_reg.trig <= sct_pkg::RST_TRIGGER;
            state_reg.msts <= 1'b0;
            state_reg.rate <= HOLD_W'(sct_pkg::HOLD_CYCLES);
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
            state_reg.prdata <= 32'h0000_0000;
            state_reg.sda_oe <= 1'b0;
            state_reg.scl_oe <= 1'b0;
            state_reg.start_done <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register; lines only ever pull low.
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign bus_data_line_out = 1'b0;
    assign bus_data_line_oe = state_reg.sda_oe;
    assign bus_clock_line_out = 1'b0;
    assign bus_clock_line_oe = state_reg.scl_oe;
    assign start_done = state_reg.start_done;
    assign master_state_flag = state_reg.msts;

    // Checks on the sequencer and the trigger bit.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // Cycles spent with data low before the clock falls.
    logic [HOLD_W-1:0] chk_hold_cnt;
    always_ff @(posedge clk_sys) begin
        if (!rst_b || state_reg.fsm != sct_pkg::ST_HOLD) begin
            chk_hold_cnt <= '0;
        end else begin
            chk_hold_cnt <= chk_hold_cnt + HOLD_W'(1);
        end
    end

    sequence s_fresh_start;
        state_reg.fsm == sct_pkg::ST_IDLE && state_reg.trig && !abort
            && !wr_clr && !master_wait && !bus_busy;
    endsequence

    sequence s_data_then_clock;
        (bus_data_line_oe && !bus_clock_line_oe)[*1] ##1
            (bus_data_line_oe && !bus_clock_line_oe);
    endsequence

    chk_no_trig_idle: assert property (
        state_reg.fsm == sct_pkg::ST_IDLE && !state_reg.trig |=>
            state_reg.fsm == sct_pkg::ST_IDLE && !bus_data_line_oe)
        else $error("start began without a trigger");

    chk_data_before_clock: assert property (
        s_fresh_start |=> s_data_then_clock or
            (bus_data_line_oe && (state_reg.rate <= HOLD_W'(1) || abort)))
        else $error("data line did not fall before the clock");

    chk_pending_kept: assert property (
        state_reg.fsm == sct_pkg::ST_IDLE && state_reg.trig && bus_busy
            && !master_wait && !abort && !wr_clr |=>
            state_reg.fsm == sct_pkg::ST_IDLE && state_reg.trig)
        else $error("reserved start request not kept");

    chk_pending_fires: assert property (
        s_fresh_start |=> state_reg.fsm == sct_pkg::ST_HOLD)
        else $error("reserved start did not fire on a free bus");

    chk_restart_path: assert property (
        state_reg.fsm == sct_pkg::ST_IDLE && state_reg.trig && master_wait
            && !abort && !wr_clr |=>
            state_reg.fsm == sct_pkg::ST_RS_SDA && bus_clock_line_oe
            && !bus_data_line_oe)
        else $error("wait did not turn into a repeated start");

    chk_trig_cleared: assert property (
        (arb_lost || wr_clr || start_done) && !wr_set |=> !state_reg.trig)
        else $error("start trigger not cleared");

    chk_trig_source: assert property (
        $rose(state_reg.trig) |-> $past(wr_set))
        else $error("start trigger set without a write");

    chk_master_flag: assert property (
        $rose(start_done) |-> master_state_flag && bus_clock_line_oe
            && bus_data_line_oe)
        else $error("master flag missing after start");

    chk_read_zero: assert property (
        $rose(pready) && $past(paddr) == sct_pkg::OFS_CTRL |->
            prdata[sct_pkg::CTRL_START_BIT] == 1'b0
            && prdata[sct_pkg::CTRL_STOP_BIT] == 1'b0)
        else $error("trigger bits read back nonzero");

    chk_hold_length: assert property (
        $rose(start_done) && !$past(abort) |->
            $past(chk_hold_cnt) + HOLD_W'(1)
                == hold_len($past(state_reg.rate)))
        else $error("start hold interval has wrong length");

endmodule : sct_start_trigger

// >>> verilog/sct_pkg.sv
package sct_pkg;

    // Register byte offsets on the APB.
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_HOLD = 12'h008;

    // Control register field positions.
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_START_BIT = 1;
    localparam int unsigned CTRL_STOP_BIT = 2;
    localparam int unsigned CTRL_EXIT_BIT = 3;

    // Status register field positions.
    localparam int unsigned STAT_MSTS_BIT = 0;
    localparam int unsigned STAT_PEND_BIT = 1;
    localparam int unsigned STAT_BUSY_BIT = 2;
    localparam int unsigned STAT_SCL_BIT = 3;
    localparam int unsigned STAT_SDA_BIT = 4;

    // Timing: system clock period and the standard start hold time.
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned HOLD_TIME_NS = 4000;
    localparam int unsigned HOLD_CYCLES =
        (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset values.
    localparam logic RST_ENABLE = 1'h0;
    localparam logic RST_TRIGGER = 1'h0;

    // Start sequencer states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RS_SDA = 5'h02,
        ST_RS_SCL = 5'h04,
        ST_HOLD = 5'h08,
        ST_DONE = 5'h10
    } sct_fsm_t;

endpackage : sct_pkg

// >>> verilog/sct_hold_timer.sv
`timescale 1ns/10ps
module sct_hold_timer #(
    parameter int unsigned CNT_W = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Load request and interval in cycles, at least one.
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    // High once the loaded interval has run out.
    output logic expired
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // A load of N makes the interval last N cycles counting the load edge.
    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = load_val - CNT_W'(1);
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Expiry is seen from the cycle the count reaches zero.
    assign expired = (cnt_reg == '0);

endmodule : sct_hold_timer

// >>> tb/sct_bus_partner.sv
`timescale 1ns/10ps
module sct_bus_partner (
    // Clock.
    input wire logic clk_sys,
    // Pull-down enables of the device.
    input wire logic data_oe,
    input wire logic clock_oe,
    // Slow mode holds the clock low after each release.
    input wire logic slow,
    // Line levels and start conditions seen on the wire.
    output logic data_line,
    output logic clock_line,
    output int starts
);
    logic [2:0] hold_cnt = 3'h0;
    logic clk_d = 1'b0;

    // Both lines have pull-ups, so a released line goes high.
    assign data_line = ~data_oe;
    assign clock_line = ~(clock_oe | (slow & clk_d) | (hold_cnt != 3'h0));

    // A slow slave stretches the clock low for a few cycles.
    always @(posedge clk_sys) begin
        clk_d <= clock_oe;
        if (slow && clk_d && !clock_oe) begin
            hold_cnt <= 3'h5;
        end else if (hold_cnt != 3'h0) begin
            hold_cnt <= hold_cnt - 3'h1;
        end
    end

    // A data fall while the clock is high counts as a start.
    initial starts = 0;
    always @(negedge data_line) begin
        if (clock_line === 1'b1) begin
            starts++;
        end
    end
endmodule : sct_bus_partner

// >>> tb/sct_start_trigger_test.sv
`timescale 1ns/10ps
module sct_start_trigger_test;
    localparam logic [31:0] HOLD = 32'h2;
    localparam logic [11:0] CT = sct_pkg::OFS_CTRL;
    localparam logic [11:0] ST = sct_pkg::OFS_STATUS;
    localparam int P_ACK = 0;
    localparam int P_STOP = 1;
    localparam int P_LOST = 2;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, err, sda, scl, sda_oe, scl_oe, done, mflag;
    logic bus_busy = 1'b0, master_wait = 1'b0, arb_lost = 1'b0;
    logic stop_det = 1'b0, engine_ack = 1'b0, slow = 1'b0;
    logic sda_o, scl_o;
    int starts, s0, error_cnt = 0, cmp_count = 0;

    // Free-running system clock.
    always #25 clk_sys = ~clk_sys;

    sct_start_trigger i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_busy(bus_busy), .master_wait(master_wait), .arb_lost(arb_lost),
        .stop_detected(stop_det), .engine_ack(engine_ack),
        .bus_data_line_in(sda), .bus_data_line_out(sda_o),
        .bus_data_line_oe(sda_oe), .bus_clock_line_in(scl),
        .bus_clock_line_out(scl_o), .bus_clock_line_oe(scl_oe),
        .start_done(done), .master_state_flag(mflag));

    sct_bus_partner i_far (.clk_sys(clk_sys), .data_oe(sda_oe),
        .clock_oe(scl_oe), .slow(slow), .data_line(sda), .clock_line(scl),
        .starts(starts));

    // Verdict and end of run.
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (n >= 20) begin
            error_cnt++;
            results();
        end
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask : rd

    // Raises one of the event inputs for exactly one cycle.
    task automatic pulse(input int w);
        engine_ack <= (w == P_ACK);
        stop_det <= (w == P_STOP);
        arb_lost <= (w == P_LOST);
        @(posedge clk_sys);
        engine_ack <= 1'b0;
        stop_det <= 1'b0;
        arb_lost <= 1'b0;
        @(posedge clk_sys);
    endtask : pulse

    // Waits for a start, checks hold gap and flag, then hands the lines on.
    task automatic run_start;
        int n, t;
        n = 0;
        t = -1;
        do begin
            @(posedge clk_sys);
            n++;
            if (sda_oe === 1'b1 && t < 0) t = n;
        end while (done !== 1'b1 && n < 400);
        if (n >= 400) begin
            error_cnt++;
            results();
        end
        chk(n - t, HOLD);
        chk({scl_oe, sda_oe, mflag, sda_o, scl_o}, 32'h1C);
        pulse(P_ACK);
        @(posedge clk_sys);
        chk({sda_oe, scl_oe}, 32'h0);
    endtask : run_start

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(CT, 32'h0, 32'hFFFFFFFF);
        rd(ST, 32'h18, 32'hFFFFFFFF);
        rd(sct_pkg::OFS_HOLD, 32'h50, 32'hFFFFFFFF);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, sct_pkg::OFS_HOLD, HOLD);
        rd(sct_pkg::OFS_HOLD, HOLD, 32'hFFFF);
        s0 = starts;
        apb(1'b1, CT, 32'h2);
        repeat (8) @(posedge clk_sys);
        chk({sda_oe, scl_oe, 30'(starts - s0)}, 32'h0);
        apb(1'b1, CT, 32'h3);
        run_start();
        rd(ST, 32'h1, 32'h3);
        chk(starts - s0, 32'h1);
        master_wait <= 1'b1;
        slow <= 1'b1;
        apb(1'b1, CT, 32'h3);
        run_start();
        master_wait <= 1'b0;
        slow <= 1'b0;
        chk(starts - s0, 32'h2);
        pulse(P_STOP);
        bus_busy <= 1'b1;
        apb(1'b1, CT, 32'h3);
        repeat (10) @(posedge clk_sys);
        chk({sda_oe, scl_oe, 30'(starts - s0)}, 32'h2);
        rd(CT, 32'h1, 32'hFFFFFFFF);
        rd(ST, 32'h2, 32'h2);
        bus_busy <= 1'b0;
        run_start();
        chk(starts - s0, 32'h3);
        bus_busy <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, CT, 32'h3);
            rd(ST, 32'h2, 32'h2);
            case (k)
                0: apb(1'b1, CT, 32'h1);
                1: apb(1'b1, CT, 32'h0);
                2: apb(1'b1, CT, 32'h9);
                default: pulse(P_LOST);
            endcase
            rd(ST, 32'h0, 32'h2);
        end
        bus_busy <= 1'b0;
        pulse(P_STOP);
        repeat (10) @(posedge clk_sys);
        chk({sda_oe, scl_oe, 30'(starts - s0)}, 32'h3);
        // Arbitration loss in the hold phase releases the data line at once; the clock is already released.
        apb(1'b1, CT, 32'h3);
        pulse(P_LOST);
        chk({sda_oe, scl_oe, mflag}, 32'h0);
        rd(ST, 32'h0, 32'h7);
        results();
    end
endmodule : sct_start_trigger_test
